/* hdl/ccl_pkg.sv */
// Package with register map, field positions and shared types of the comparator control logic
//
// Notes on behaviour
// - Comparator runs while comparator_enable is one, powered down while zero.
// - Reported output is non-inverting above inverting, flipped by output_invert.
// - noninv_ref_select picks internal reference, else the positive input pin.
// - inv_channel_select picks negative input pin one, else pin zero.
// - Output pin driven only with pin enable, comparator on, direction cleared.
// - Internal result registered each instruction cycle; pin path unregistered unless synced.
// - comparator_output is read-only; same value on register bit and pin.
// - First mismatch latch captures result on each control0 read or write, holds otherwise.
// - Second mismatch latch updates on every phase_one of the instruction cycle.
// - Mismatch is the exclusive-or of both latches.
// - Every write to control0 also refreshes the first latch.
// - Interrupt flag sets on the mismatch rising edge, not its level.
// - Mismatch detection works regardless of output_pin_enable.
// - Software clears the flag by writing zero, may set it by writing one.
// - Request forwarded only with all three enables; flag sets regardless.
// - A change coinciding with a control0 read at phase_two may lose the flag.
// - Enabled comparator keeps operating during sleep.
// - Change wakes from sleep with irq enable and peripheral gate set.
// - Reset returns control1 to reset state, comparator and reference off.
// - Gate source select zero makes comparator output the timer gate.
// - With sync, output latched on falling edge of the prescaled timer clock.
package ccl_pkg;

    // Byte addresses on APB
    localparam logic [7:0] CCL_ADDR_CTRL0  = 8'h00;
    localparam logic [7:0] CCL_ADDR_CTRL1  = 8'h04;
    localparam logic [7:0] CCL_ADDR_IRQ    = 8'h08;

    // comp_control0 fields
    localparam int CCL_C0_ENABLE = 7;
    localparam int CCL_C0_OUTPUT = 6;
    localparam int CCL_C0_PINEN  = 5;
    localparam int CCL_C0_INVERT = 4;
    localparam int CCL_C0_REFSEL = 2;
    localparam int CCL_C0_CHSEL  = 0;
    localparam logic [7:0] CCL_C0_WMASK = 8'hb5;
    localparam logic [7:0] CCL_C0_RESET = 8'h00;

    // comp_control1 fields
    localparam int CCL_C1_ALTCLK = 4;
    localparam int CCL_C1_HYST   = 3;
    localparam int CCL_C1_GATESS = 1;
    localparam int CCL_C1_SYNC   = 0;
    localparam logic [7:0] CCL_C1_WMASK = 8'h1b;
    localparam logic [7:0] CCL_C1_RESET = 8'h02;

    // Interrupt register fields
    localparam int CCL_IRQ_FLAG = 0;
    localparam int CCL_IRQ_EN   = 1;
    localparam int CCL_IRQ_PERIPH_IRQ_GATE = 2;
    localparam int CCL_IRQ_GIE  = 3;
    localparam logic [7:0] CCL_IRQ_RESET = 8'h00;

    // Instruction cycle: four system clocks per cycle, phase_one first
    localparam logic [1:0] CCL_PH_ONE = 2'd0;
    localparam logic [1:0] CCL_PH_TWO = 2'd1;

    // Bias settling time, software side only
    localparam int CCL_SETTLE_NS     = 1000;
    localparam int CCL_CLK_PERIOD_NS = 5;
    localparam int CCL_SETTLE_CYC    = (CCL_SETTLE_NS + CCL_CLK_PERIOD_NS - 1) / CCL_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CCL_Q1 = 2'b00,
        CCL_Q2 = 2'b01,
        CCL_Q3 = 2'b11,
        CCL_Q4 = 2'b10
    } ccl_phase_t;

    typedef struct packed {
        logic pos_pin;
        logic internal_ref;
        logic neg_pin0;
        logic neg_pin1;
    } ccl_analog_sel_t;

    typedef struct packed {
        logic cmp_enable;
        logic noninv_is_ref;
        logic inv_is_pin1;
        logic hyst_enable;
    } ccl_analog_ctl_t;

endpackage

/* hdl/ccl_top.sv */
// Comparator control logic: APB registers, mismatch detector, pin and timer gate outputs
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

module ccl_top (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    // APB slave
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [7:0]              i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic                         o_pready,
    output logic [31:0]                  o_prdata,
    output logic                         o_pslverr,
    // Analog core
    input  wire logic                    i_cmp_raw,
    output ccl_pkg::ccl_analog_ctl_t     o_analog_ctl,
    // Port pin and timer
    input  wire logic                    i_pin_direction,
    input  wire logic                    i_port_latch,
    input  wire logic                    i_timer_clk,
    input  wire logic                    i_sleep,
    output logic                         o_pin_out,
    output logic                         o_pin_oe,
    output logic                         o_timer_gate,
    output logic                         o_timer_gate_sel,
    output logic                         o_timer_alt_clk,
    output logic                         o_irq,
    output logic                         o_wake
);
    import ccl_pkg::*;

    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] irq_reg;
    ccl_phase_t phase;
    logic [2:0] cmp_sync;
    logic [2:0] tclk_sync;
    logic       cmp_stable;
    logic       cmp_int;
    logic       latch_rd;
    logic       latch_q1;
    logic       mismatch;
    logic       mismatch_d;
    logic       sync_out;
    logic       out_async;
    logic       out_pin_val;
    logic       rd_ctrl0;
    logic       wr_ctrl0;
    logic       wr_ctrl1;
    logic       wr_irq;
    logic       access;
    logic       addr_ok;
    logic       flag_set;
    logic [7:0] rdata;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; every access answers in its first access cycle
    assign access   = i_psel & i_penable;
    assign addr_ok  = (i_paddr == CCL_ADDR_CTRL0) | (i_paddr == CCL_ADDR_CTRL1)
                    | (i_paddr == CCL_ADDR_IRQ);
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~addr_ok;
    assign rd_ctrl0 = access & (i_paddr == CCL_ADDR_CTRL0);
    assign wr_ctrl0 = rd_ctrl0 & i_pwrite;
    assign wr_ctrl1 = access & i_pwrite & (i_paddr == CCL_ADDR_CTRL1);
    assign wr_irq   = access & i_pwrite & (i_paddr == CCL_ADDR_IRQ);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl0 <= CCL_C0_RESET;
        end else if (wr_ctrl0) begin
            ctrl0 <= i_pwdata[7:0] & CCL_C0_WMASK;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl1 <= CCL_C1_RESET;
        end else if (wr_ctrl1) begin
            ctrl1 <= i_pwdata[7:0] & CCL_C1_WMASK;
        end
    end

    always_comb begin
        rdata = 8'h00;
        case (i_paddr)
            CCL_ADDR_CTRL0: begin
                rdata = ctrl0;
                rdata[CCL_C0_OUTPUT] = cmp_int;
            end
            CCL_ADDR_CTRL1: begin
                rdata = ctrl1;
            end
            CCL_ADDR_IRQ: begin
                rdata = irq_reg;
            end
            default: begin
                rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel & ~i_penable & ~i_pwrite) begin
            o_prdata <= {24'h00_0000, rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog steering
    assign o_analog_ctl.cmp_enable    = ctrl0[CCL_C0_ENABLE];
    assign o_analog_ctl.noninv_is_ref = ctrl0[CCL_C0_REFSEL];
    assign o_analog_ctl.inv_is_pin1   = ctrl0[CCL_C0_CHSEL];
    assign o_analog_ctl.hyst_enable   = ctrl1[CCL_C1_HYST];

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for the raw compare bit and the timer clock
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cmp_sync  <= 3'h0;
            tclk_sync <= 3'h0;
        end else begin
            cmp_sync  <= {cmp_sync[1:0], i_cmp_raw};
            tclk_sync <= {tclk_sync[1:0], i_timer_clk};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cmp_stable <= 1'b0;
        end else if (cmp_sync[1] == cmp_sync[2]) begin
            cmp_stable <= cmp_sync[2];
        end
    end

    // Disabled comparator reads low; polarity applied after
    assign out_async = (ctrl0[CCL_C0_ENABLE] & cmp_stable) ^ ctrl0[CCL_C0_INVERT];

    ////////////////////////////////////////////////////////////////////////////
    // Instruction cycle phases
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            phase <= CCL_Q1;
        end else begin
            case (phase)
                CCL_Q1:  phase <= CCL_Q2;
                CCL_Q2:  phase <= CCL_Q3;
                CCL_Q3:  phase <= CCL_Q4;
                CCL_Q4:  phase <= CCL_Q1;
                default: phase <= CCL_Q1;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cmp_int <= 1'b0;
        end else if (phase == CCL_Q4) begin
            cmp_int <= out_async;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mismatch detector
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            latch_q1 <= 1'b0;
        end else if (phase == CCL_Q1) begin
            latch_q1 <= cmp_int;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            latch_rd <= 1'b0;
        end else if (rd_ctrl0) begin
            latch_rd <= latch_q1;
        end
    end

    assign mismatch = latch_rd ^ latch_q1;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            mismatch_d <= 1'b0;
        end else begin
            mismatch_d <= mismatch;
        end
    end

    // A read landing in the cycle of the edge swallows it
    assign flag_set = mismatch & ~mismatch_d & ~rd_ctrl0;

    ////////////////////////////////////////////////////////////////////////////
    // Flag and enables; hardware set wins over software clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            irq_reg <= CCL_IRQ_RESET;
        end else begin
            if (wr_irq) begin
                irq_reg[CCL_IRQ_FLAG] <= i_pwdata[CCL_IRQ_FLAG] | flag_set;
                irq_reg[CCL_IRQ_EN]   <= i_pwdata[CCL_IRQ_EN];
                irq_reg[CCL_IRQ_PERIPH_IRQ_GATE] <= i_pwdata[CCL_IRQ_PERIPH_IRQ_GATE];
                irq_reg[CCL_IRQ_GIE]  <= i_pwdata[CCL_IRQ_GIE];
            end else if (flag_set) begin
                irq_reg[CCL_IRQ_FLAG] <= 1'b1;
            end
        end
    end

    assign o_irq  = irq_reg[CCL_IRQ_FLAG] & irq_reg[CCL_IRQ_EN]
                  & irq_reg[CCL_IRQ_PERIPH_IRQ_GATE] & irq_reg[CCL_IRQ_GIE];
    assign o_wake = i_sleep & irq_reg[CCL_IRQ_FLAG]
                  & irq_reg[CCL_IRQ_EN] & irq_reg[CCL_IRQ_PERIPH_IRQ_GATE];

    ////////////////////////////////////////////////////////////////////////////
    // Timer synchronisation and output pin
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sync_out <= 1'b0;
        end else if (tclk_sync[2] & ~tclk_sync[1]) begin
            sync_out <= out_async;
        end
    end

    assign out_pin_val = ctrl1[CCL_C1_SYNC] ? sync_out : out_async;
    assign o_pin_oe    = ~i_pin_direction;
    assign o_pin_out   = (ctrl0[CCL_C0_PINEN] & ctrl0[CCL_C0_ENABLE]) ? out_pin_val
                                                                     : i_port_latch;
    assign o_timer_gate     = out_pin_val;
    assign o_timer_gate_sel = ~ctrl1[CCL_C1_GATESS];
    assign o_timer_alt_clk  = ctrl1[CCL_C1_ALTCLK];

endmodule

/* dv/ccl_properties.sv */
// Port-level assertions for the comparator control logic
`timescale 1ns/100ps

module ccl_properties (
    input wire logic                     i_clk_sys,
    input wire logic                     i_rst_n,
    input wire logic                     i_psel,
    input wire logic                     i_penable,
    input wire logic                     i_pwrite,
    input wire logic [7:0]               i_paddr,
    input wire logic [31:0]              i_pwdata,
    input wire logic [31:0]              o_prdata,
    input wire logic                     i_cmp_raw,
    input wire ccl_pkg::ccl_analog_ctl_t o_analog_ctl,
    input wire logic                     i_port_latch,
    input wire logic                     i_sleep,
    input wire logic                     o_pin_out,
    input wire logic                     o_timer_gate,
    input wire logic                     o_timer_gate_sel,
    input wire logic                     o_irq,
    input wire logic                     o_wake
);
    import ccl_pkg::*;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [2:0] ie;
    logic       rd;
    logic       live;
    logic       dark;
    ////////////////////////////////////////////////////////////
    // Shadow of the bits that software writes
    assign rd = i_psel && i_penable && !i_pwrite;
    assign live = c0[7] && c0[5] && !c1[0];
    assign dark = !c0[7] && !c1[0];
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            c0 <= CCL_C0_RESET;
            c1 <= CCL_C1_RESET;
            ie <= 3'h0;
        end else if (i_psel && i_penable && i_pwrite) begin
            if (i_paddr == CCL_ADDR_CTRL0) c0 <= i_pwdata[7:0] & CCL_C0_WMASK;
            if (i_paddr == CCL_ADDR_CTRL1) c1 <= i_pwdata[7:0] & CCL_C1_WMASK;
            if (i_paddr == CCL_ADDR_IRQ) ie <= i_pwdata[3:1];
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    ctl_follow_a: assert property (o_analog_ctl == {c0[7], c0[2], c0[0], c1[3]})
        else $error("analog control differs from register");
    out_pol_a: assert property ((live && $stable(i_cmp_raw) && $stable(c0))[*8]
        |-> o_pin_out == (i_cmp_raw ^ c0[4]) && o_timer_gate == o_pin_out)
        else $error("pin value does not follow comparator");
    off_level_a: assert property ((dark && $stable(c0))[*8] |-> o_timer_gate == c0[4])
        else $error("disabled comparator output wrong");
    pin_latch_a: assert property (!(c0[7] && c0[5]) |-> o_pin_out == i_port_latch)
        else $error("pin not given to port latch");
    gate_sel_a: assert property (o_timer_gate_sel == !c1[CCL_C1_GATESS])
        else $error("timer gate select wrong");
    irq_gate_a: assert property (o_irq |-> ie == 3'h7)
        else $error("request without all enables");
    wake_gate_a: assert property ((o_wake |-> i_sleep && ie[1:0] == 2'h3)
        and (i_sleep && ie == 3'h7 |-> o_wake == o_irq))
        else $error("wake condition wrong");
    rd_ctrl0_a: assert property (rd && i_paddr == CCL_ADDR_CTRL0
        |-> (o_prdata & 32'hffffffbf) == {24'h0, c0})
        else $error("control0 read data wrong");
    rd_ctrl1_a: assert property (rd && i_paddr == CCL_ADDR_CTRL1 |-> o_prdata == {24'h0, c1})
        else $error("control1 read data wrong");
endmodule

/* dv/ccl_analog_model.sv */
// Behavioural analog comparator core with input routing and a free-running timer clock
`timescale 1ns/100ps

module ccl_analog_model (
    input  wire logic                     i_clk_sys,
    input  wire ccl_pkg::ccl_analog_ctl_t i_ctl,
    input  wire ccl_pkg::ccl_analog_sel_t i_lvl,
    output logic                          o_cmp_raw,
    output logic                          o_timer_clk
);
    import ccl_pkg::*;
    logic plus;
    logic minus;
    logic junk = 1'b0;
    assign plus = i_ctl.noninv_is_ref ? i_lvl.internal_ref : i_lvl.pos_pin;
    assign minus = i_ctl.inv_is_pin1 ? i_lvl.neg_pin1 : i_lvl.neg_pin0;
    // A powered-down core has no valid result, so it chatters
    always @(posedge i_clk_sys) junk <= ~junk;
    assign #2 o_cmp_raw = i_ctl.cmp_enable ? plus & ~minus : junk;
    initial o_timer_clk = 1'b0;
    always #7.3 o_timer_clk = ~o_timer_clk;
endmodule

/* dv/ccl_top_tb.sv */
// Self-checking bench for the comparator control logic
`timescale 1ns/100ps

module ccl_top_tb;
    import ccl_pkg::*;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            psel = 1'b0;
    logic            pen = 1'b0;
    logic            pwr = 1'b0;
    logic            pdir = 1'b1;
    logic            plat = 1'b0;
    logic            sleep = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0;
    logic            pready, pslverr, raw, tclk, irq, wake;
    logic [31:0]     prdata;
    ccl_analog_ctl_t actl;
    ccl_analog_sel_t lvl = 4'h0;
    logic [8:0]      exq[$];
    logic [31:0]     seed = 32'h9627;
    logic [31:0]     rr = 32'h9627;
    logic [7:0]      c0;
    logic [7:0]      c1;
    logic [7:0]      ex;
    logic            tgate, poe, altclk;
    int              error_cnt = 0;
    int              compares = 0;
    always #2.5 clk = ~clk;
    ccl_top ccl_top_inst (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_cmp_raw(raw), .o_analog_ctl(actl), .i_pin_direction(pdir),
        .i_port_latch(plat), .i_timer_clk(tclk), .i_sleep(sleep), .o_pin_out(),
        .o_pin_oe(poe), .o_timer_gate(tgate), .o_timer_gate_sel(), .o_timer_alt_clk(altclk),
        .o_irq(irq), .o_wake(wake));
    ccl_analog_model ccl_analog_model_inst (
        .i_clk_sys(clk), .i_ctl(actl), .i_lvl(lvl), .o_cmp_raw(raw), .o_timer_clk(tclk));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] rd0(input logic [7:0] c, input ccl_analog_sel_t l);
        logic p;
        logic m;
        p = c[2] ? l.internal_ref : l.pos_pin;
        m = c[0] ? l.neg_pin1 : l.neg_pin0;
        return (c & CCL_C0_WMASK) | {1'b0, (c[7] & p & ~m) ^ c[4], 6'h0};
    endfunction
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
        if (!w) exq.push_back(e);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pins(input logic [1:0] e);
        @(negedge clk);
        chk("irq_wake", {31'h0, irq, wake}, {31'h0, e});
        @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        rr <= lfsr(rr);
        pdir <= rr[3];
        plat <= rr[7];
        chk("pin_oe", {32'h0, poe}, {32'h0, ~pdir});
        if (psel && pen && pready && !pwr && exq.size() > 0) begin
            chk("prdata", {pslverr, prdata}, {exq[0][8], 24'h0, exq[0][7:0]});
            void'(exq.pop_front());
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, CCL_ADDR_CTRL0, 8'h0, {1'b0, CCL_C0_RESET});
        apb(0, CCL_ADDR_CTRL1, 8'h0, {1'b0, CCL_C1_RESET});
        apb(0, CCL_ADDR_IRQ, 8'h0, {1'b0, CCL_IRQ_RESET});
        apb(1, 8'h0c, 8'hff, 9'h0);
        apb(0, 8'h0c, 8'h0, 9'h100);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(lfsr(seed));
            c0 = seed[7:0];
            c1 = seed[23:16];
            if (!c1[CCL_C1_GATESS]) c1[CCL_C1_SYNC] = 1'b1;
            lvl <= seed[11:8];
            apb(1, CCL_ADDR_CTRL1, c1, 9'h0);
            apb(1, CCL_ADDR_CTRL0, c0, 9'h0);
            repeat (11) @(posedge clk);
            @(negedge clk);
            ex = rd0(c0, lvl);
            chk("timer_gate", {32'h0, tgate}, {32'h0, ex[CCL_C0_OUTPUT]});
            chk("alt_clk", {32'h0, altclk}, {32'h0, c1[CCL_C1_ALTCLK]});
            @(posedge clk);
            apb(0, CCL_ADDR_CTRL0, 8'h0, {1'b0, ex});
            apb(0, CCL_ADDR_CTRL1, 8'h0, {1'b0, c1 & CCL_C1_WMASK});
        end
        $display("test config done");
        apb(1, CCL_ADDR_CTRL0, 8'h80, 9'h0);
        lvl <= 4'h0;
        repeat (CCL_SETTLE_CYC) @(posedge clk);
        apb(1, CCL_ADDR_CTRL0, 8'h80, 9'h0);
        apb(1, CCL_ADDR_IRQ, 8'h0e, 9'h0);
        apb(0, CCL_ADDR_IRQ, 8'h0, 9'h00e);
        lvl <= 4'h8;
        repeat (16) @(posedge clk);
        apb(0, CCL_ADDR_IRQ, 8'h0, 9'h00f);
        pins(2'b10);
        apb(1, CCL_ADDR_IRQ, 8'h0e, 9'h0);
        apb(0, CCL_ADDR_IRQ, 8'h0, 9'h00e);
        apb(1, CCL_ADDR_CTRL0, 8'h80, 9'h0);
        lvl <= 4'h0;
        repeat (16) @(posedge clk);
        apb(0, CCL_ADDR_IRQ, 8'h0, 9'h00f);
        apb(1, CCL_ADDR_IRQ, 8'h01, 9'h0);
        apb(0, CCL_ADDR_IRQ, 8'h0, 9'h001);
        pins(2'b00);
        $display("test interrupt done");
        sleep <= 1'b1;
        apb(1, CCL_ADDR_IRQ, 8'h06, 9'h0);
        apb(0, CCL_ADDR_CTRL0, 8'h0, 9'h080);
        pins(2'b00);
        lvl <= 4'h8;
        repeat (16) @(posedge clk);
        pins(2'b01);
        apb(1, CCL_ADDR_IRQ, 8'h0f, 9'h0);
        pins(2'b11);
        sleep <= 1'b0;
        apb(1, CCL_ADDR_IRQ, 8'h0e, 9'h0);
        pins(2'b00);
        $display("test sleep done");
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
endmodule

bind ccl_top ccl_properties ccl_properties_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .i_cmp_raw(i_cmp_raw), .o_analog_ctl(o_analog_ctl), .i_port_latch(i_port_latch),
    .i_sleep(i_sleep), .o_pin_out(o_pin_out), .o_timer_gate(o_timer_gate),
    .o_timer_gate_sel(o_timer_gate_sel), .o_irq(o_irq), .o_wake(o_wake));
